// File: logic/cioc_addr_gen.sv
// logical channel and subaddress adder
`timescale 1ns/1ns
`default_nettype none
module cioc_addr_gen
    import cioc_pkg::*;
(
    input wire logic [2:0] i_reg_sel,
    input wire logic [31:0] i_reg_data,
    input wire logic [CONST_W-1:0] i_const,
    output logic [CONST_W-1:0] o_addr
);
    // 16-bit sum, carry out of the top bit falls away
    always_comb begin
        if (i_reg_sel != 3'h0) begin
            o_addr = i_reg_data[CONST_W-1:0] + i_const; // [RULE3] [RULE21]
        end else begin
            o_addr = i_const; // [RULE3]
        end
    end
endmodule
`default_nettype wire

// File: logic/cioc_decoder.sv
// channel control instruction decoder and dispatcher
//
// Notes on behaviour
// [RULE1] accept only when the opcode field holds all ones
// [RULE2] augment field must hold seven for the whole group
// [RULE3] address is register plus constant, or constant when selector zero
// [RULE4] sub op 5 resets the addressed channel to idle
// [RULE5] channel reset covers subchannels, leaves controllers and devices alone
// [RULE6] channel reset drops requesting or active interrupt level
// [RULE7] sub op 6 halts the controller promptly and cleanly
// [RULE8] a device end after halt marks the controller free again
// [RULE9] a halt yields exactly one device end for its operation
// [RULE10] sub op 7 makes the controller move to the issuing channel
// [RULE11] sub op 8 resets the controller completely
// [RULE12] controller reset also clears subchannel and all status
// [RULE13] sub op 9 arms the control store load interlock
// [RULE14] software issues the enable first of a two step load
// [RULE15] acceptance is condition code 0000 or 1000
// [RULE16] wrong channel class takes the undefined instruction trap
// [RULE17] condition code stays set after completion for branches
// [RULE18] refusal codes 0001, 0010, 0011, 0100, 0101
// [RULE19] 0000 means activated with echo, 1000 queued without
// [RULE20] store write must directly follow enable, else system check; the code lets non-enable issues to other channels come between
// [RULE21] address sum is 16 bits, carry discarded
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cioc_decoder
    import cioc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_instr_valid,
    input wire logic [INSTR_W-1:0] i_instr,
    output logic [2:0] o_reg_sel,
    input wire logic [31:0] i_reg_data,
    input wire logic [3:0] i_bus_addr,
    input wire logic [31:0] i_bus_wdata,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    output logic [31:0] o_bus_rdata,
    output logic o_chan_req,
    output logic [3:0] o_chan_op,
    output logic [CONST_W-1:0] o_chan_addr,
    input wire logic i_chan_busy,
    input wire logic i_chan_ack,
    input wire logic [3:0] i_chan_cc,
    input wire logic i_chan_dev_end,
    input wire logic [CHAN_W-1:0] i_chan_dev_chan,
    output logic o_dev_end,
    output logic [3:0] o_cc,
    output logic o_done,
    output logic o_reject,
    output logic o_trap_undef,
    output logic o_trap_syscheck
);
    // ****************************************
    // state and decode
    // ****************************************
    cioc_state_t state_q;
    logic [INSTR_W-1:0] instr_q;
    logic [CONST_W-1:0] addr_q;
    logic [CONST_W-1:0] sum;
    logic [1:0] class_q [NUM_CHAN];
    logic [CHAN_W-1:0] class_idx_q;
    logic [7:0] wait_cnt_q;
    logic armed;
    logic [CHAN_W-1:0] armed_chan;
    logic halt_arm_q;
    logic mute_q;
    logic [CHAN_W-1:0] halt_chan_q;
    logic [3:0] sub_op;
    logic [CHAN_W-1:0] chan;
    logic instr_ok;
    logic chan_present;
    logic chan_classf;
    logic wcs_ok;
    logic do_issue;
    logic timeout;

    assign sub_op = instr_q[SUB_LSB +: 4];
    assign chan = addr_q[CHAN_LSB +: CHAN_W];
    assign instr_ok = i_instr[OP_LSB +: 6] == OPCODE_IO && // [RULE1]
        i_instr[AUG_LSB +: 3] == AUG_IO && // [RULE2]
        sub_supported(i_instr[SUB_LSB +: 4]);
    assign chan_present = class_q[chan][0];
    assign chan_classf = class_q[chan][1];
    assign wcs_ok = sub_op != SUB_WCS_WRITE ||
        (armed && armed_chan == chan); // [RULE20]
    assign do_issue = state_q == ST_CHECK && chan_present &&
        chan_classf && wcs_ok && !i_chan_busy;
    assign timeout = wait_cnt_q == 8'(ACK_TIMEOUT_CYC - 1);

    cioc_addr_gen u_addr (
        .i_reg_sel(o_reg_sel),
        .i_reg_data(i_reg_data),
        .i_const(instr_q[CONST_W-1:0]),
        .o_addr(sum)
    );

    cioc_wcs_interlock u_lock (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_issue(do_issue),
        .i_sub_op(sub_op),
        .i_chan(chan),
        .o_armed(armed),
        .o_chan(armed_chan)
    );

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (i_instr_valid && instr_ok) begin
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: state_q <= ST_CHECK;
                ST_CHECK: state_q <= do_issue ? ST_WAIT : ST_IDLE;
                ST_WAIT: begin
                    if (i_chan_ack || timeout) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // register selector goes out a cycle ahead of the sum
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            instr_q <= 32'h0000_0000;
            o_reg_sel <= 3'h0;
            addr_q <= 16'h0000;
        end else begin
            if (state_q == ST_IDLE && i_instr_valid && instr_ok) begin
                instr_q <= i_instr;
                o_reg_sel <= i_instr[REG_LSB +: 3];
            end
            if (state_q == ST_FETCH) begin
                addr_q <= sum; // [RULE3]
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wait_cnt_q <= 8'h00;
        end else if (state_q == ST_WAIT) begin
            wait_cnt_q <= wait_cnt_q + 8'h01;
        end else begin
            wait_cnt_q <= 8'h00;
        end
    end

    // ****************************************
    // results: condition code and traps
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_cc <= CC_ACTIVATED;
            o_done <= 1'b0;
            o_reject <= 1'b0;
            o_trap_undef <= 1'b0;
            o_trap_syscheck <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_trap_undef <= 1'b0;
            o_trap_syscheck <= 1'b0;
            // instructions not ours, or arriving mid-execution
            o_reject <= i_instr_valid &&
                (state_q != ST_IDLE || !instr_ok); // [RULE1] [RULE2]
            if (state_q == ST_CHECK) begin
                if (!chan_present) begin
                    o_cc <= CC_CHAN_INOP; // [RULE18]
                    o_done <= 1'b1;
                end else if (!chan_classf) begin
                    // cc left untouched on a trap
                    o_trap_undef <= 1'b1; // [RULE16]
                end else if (!wcs_ok) begin
                    o_trap_syscheck <= 1'b1; // [RULE20]
                end else if (i_chan_busy) begin
                    o_cc <= CC_CHAN_BUSY; // [RULE18]
                    o_done <= 1'b1;
                end
            end else if (state_q == ST_WAIT) begin
                if (i_chan_ack) begin
                    // held until the next completion [RULE17]
                    o_cc <= cc_assigned(i_chan_cc) ? i_chan_cc :
                        CC_UNSUPPORTED; // [RULE15] [RULE19]
                    o_done <= 1'b1;
                end else if (timeout) begin
                    // silent channel counts as inoperable
                    o_cc <= CC_CHAN_INOP; // [RULE18]
                    o_done <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // channel request
    // ****************************************
    // the channel itself performs the reset, halt, grab and
    // controller reset actions named by o_chan_op
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_chan_req <= 1'b0;
            o_chan_op <= 4'h0;
            o_chan_addr <= 16'h0000;
        end else begin
            o_chan_req <= do_issue;
            if (do_issue) begin
                // [RULE4] [RULE5] [RULE6] [RULE7] [RULE10]
                // [RULE11] [RULE12] [RULE13]
                o_chan_op <= sub_op;
                o_chan_addr <= addr_q;
            end
        end
    end

    // ****************************************
    // device end filter after a halt
    // ****************************************
    // limitation: while muted, every device end of that channel is
    // dropped until the next instruction is issued to it or a halt is issued to any channel
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            halt_arm_q <= 1'b0;
            mute_q <= 1'b0;
            halt_chan_q <= 8'h00;
            o_dev_end <= 1'b0;
        end else begin
            o_dev_end <= i_chan_dev_end &&
                !(mute_q && i_chan_dev_chan == halt_chan_q); // [RULE9]
            if (i_chan_dev_end && halt_arm_q &&
                i_chan_dev_chan == halt_chan_q) begin
                halt_arm_q <= 1'b0; // [RULE8]
                mute_q <= 1'b1; // [RULE9]
            end
            // new issue overrides, so a fresh halt is never missed
            if (do_issue && chan == halt_chan_q) begin
                mute_q <= 1'b0;
                halt_arm_q <= 1'b0;
            end
            if (do_issue && sub_op == SUB_CTL_HALT) begin
                halt_arm_q <= 1'b1; // [RULE8]
                mute_q <= 1'b0;
                halt_chan_q <= chan;
            end
        end
    end

    // ****************************************
    // register port
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                class_q[i] <= CLS_RESET;
            end
            class_idx_q <= 8'h00;
        end else if (i_bus_wr && i_bus_addr == REG_CLASS) begin
            // class table steers the trap and refusal checks
            class_q[i_bus_wdata[CHAN_W-1:0]] <=
                i_bus_wdata[CLS_CLASSF_BIT:CLS_PRESENT_BIT];
            class_idx_q <= i_bus_wdata[CHAN_W-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_bus_rdata <= 32'h0000_0000;
        end else begin
            o_bus_rdata <= 32'h0000_0000;
            if (i_bus_rd) begin
                unique case (i_bus_addr)
                    REG_CLASS: begin
                        o_bus_rdata[CHAN_W-1:0] <= class_idx_q;
                        o_bus_rdata[CLS_CLASSF_BIT:CLS_PRESENT_BIT] <=
                            class_q[class_idx_q];
                    end
                    REG_STATUS: begin
                        o_bus_rdata[3:0] <= o_cc;
                        o_bus_rdata[ST_ARM_BIT] <= armed;
                        o_bus_rdata[ST_ARMCH_LSB +: CHAN_W] <= armed_chan;
                    end
                    REG_ADDR: o_bus_rdata[CONST_W-1:0] <= addr_q;
                    default: o_bus_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    localparam int ACK_LIMIT = 100;
    logic [CONST_W-1:0] exp_addr;
    assign exp_addr = (o_reg_sel == 3'h0) ? instr_q[CONST_W-1:0] :
        16'(i_reg_data[CONST_W-1:0] + instr_q[CONST_W-1:0]);

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    sequence s_take;
        state_q == ST_IDLE && i_instr_valid && instr_ok;
    endsequence
    sequence s_decode;
        state_q == ST_FETCH ##1 state_q == ST_CHECK;
    endsequence
    sequence s_unarmed_write;
        state_q == ST_CHECK && chan_present && chan_classf &&
            sub_op == SUB_WCS_WRITE && !armed;
    endsequence

    property p_opc_reject;
        state_q == ST_IDLE && i_instr_valid &&
            i_instr[OP_LSB +: 6] != OPCODE_IO
            |=> o_reject && state_q == ST_IDLE;
    endproperty
    a_opc_reject: assert property (p_opc_reject) // [RULE1]
        else $error("bad opcode was not rejected");

    property p_aug_reject;
        state_q == ST_IDLE && i_instr_valid &&
            i_instr[AUG_LSB +: 3] != AUG_IO
            |=> o_reject && !o_chan_req ##1 state_q == ST_IDLE;
    endproperty
    a_aug_reject: assert property (p_aug_reject) // [RULE2]
        else $error("bad augment was not rejected");

    property p_take_flow;
        s_take |=> s_decode;
    endproperty
    a_take_flow: assert property (p_take_flow) // [RULE1]
        else $error("accepted instruction skipped decode");

    property p_addr_form;
        state_q == ST_FETCH |=> addr_q == $past(exp_addr);
    endproperty
    a_addr_form: assert property (p_addr_form) // [RULE3] [RULE21]
        else $error("logical address formed wrongly");

    property p_class_gate;
        o_chan_req |-> chan_classf && chan_present;
    endproperty
    a_class_gate: assert property (p_class_gate) // [RULE16]
        else $error("request sent to a wrong class channel");

    property p_undef_trap;
        state_q == ST_CHECK && chan_present && !chan_classf
            |=> o_trap_undef && !o_chan_req && $stable(o_cc);
    endproperty
    a_undef_trap: assert property (p_undef_trap) // [RULE16]
        else $error("missing undefined instruction trap");

    property p_wcs_trap;
        s_unarmed_write |=> o_trap_syscheck && !o_chan_req;
    endproperty
    a_wcs_trap: assert property (p_wcs_trap) // [RULE20]
        else $error("unarmed store write not trapped");

    property p_enable_arms;
        o_chan_req && o_chan_op == SUB_WCS_ENABLE |->
            armed && armed_chan == o_chan_addr[CHAN_LSB +: CHAN_W];
    endproperty
    a_enable_arms: assert property (p_enable_arms) // [RULE13]
        else $error("load enable did not arm interlock");

    property p_cc_hold;
        $changed(o_cc) |-> o_done;
    endproperty
    a_cc_hold: assert property (p_cc_hold) // [RULE17]
        else $error("condition code moved without completion");

    property p_ack_cc;
        state_q == ST_WAIT && i_chan_ack && cc_assigned(i_chan_cc)
            |=> o_done && o_cc == $past(i_chan_cc);
    endproperty
    a_ack_cc: assert property (p_ack_cc) // [RULE15] [RULE19]
        else $error("channel condition code not reported");

    property p_busy_cc;
        state_q == ST_CHECK && chan_present && chan_classf && wcs_ok &&
            i_chan_busy |=> o_done && o_cc == CC_CHAN_BUSY;
    endproperty
    a_busy_cc: assert property (p_busy_cc) // [RULE18]
        else $error("busy channel not reported");

    property p_wait_bound;
        state_q == ST_WAIT |-> ##[0:ACK_LIMIT] state_q == ST_IDLE;
    endproperty
    a_wait_bound: assert property (p_wait_bound) // [RULE18]
        else $error("channel wait never ended");
endmodule
`default_nettype wire

// File: logic/cioc_pkg.sv
// constants and types shared by the channel control instruction decoder
package cioc_pkg;
    // ****************************************
    // instruction fields (bit 0 is the lsb)
    // ****************************************
    localparam int INSTR_W = 32;
    localparam int OP_LSB = 26;
    localparam int REG_LSB = 23;
    localparam int SUB_LSB = 19;
    localparam int AUG_LSB = 16;
    localparam int CONST_W = 16;
    localparam logic [5:0] OPCODE_IO = 6'h3F;
    localparam logic [2:0] AUG_IO = 3'h7;
    // ****************************************
    // sub operations
    // ****************************************
    localparam logic [3:0] SUB_CHAN_RESET = 4'h5;
    localparam logic [3:0] SUB_CTL_HALT = 4'h6;
    localparam logic [3:0] SUB_CTL_GRAB = 4'h7;
    localparam logic [3:0] SUB_CTL_RESET = 4'h8;
    localparam logic [3:0] SUB_WCS_ENABLE = 4'h9;
    localparam logic [3:0] SUB_WCS_WRITE = 4'hB;
    // ****************************************
    // condition codes
    // ****************************************
    localparam logic [3:0] CC_ACTIVATED = 4'h0;
    localparam logic [3:0] CC_CHAN_BUSY = 4'h1;
    localparam logic [3:0] CC_CHAN_INOP = 4'h2;
    localparam logic [3:0] CC_SUB_BUSY = 4'h3;
    localparam logic [3:0] CC_STATUS_STORED = 4'h4;
    localparam logic [3:0] CC_UNSUPPORTED = 4'h5;
    localparam logic [3:0] CC_QUEUED = 4'h8;
    // ****************************************
    // logical address, register map, timing
    // ****************************************
    localparam int CHAN_LSB = 8;
    localparam int CHAN_W = 8;
    localparam int NUM_CHAN = 256;
    localparam logic [3:0] REG_CLASS = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ADDR = 4'h8;
    localparam int CLS_PRESENT_BIT = 8;
    localparam int CLS_CLASSF_BIT = 9;
    localparam int ST_ARM_BIT = 4;
    localparam int ST_ARMCH_LSB = 8;
    localparam logic [1:0] CLS_RESET = 2'h0;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACK_TIMEOUT_NS = 10000;
    localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_CHECK,
        ST_WAIT
    } cioc_state_t;

    function automatic logic sub_supported(input logic [3:0] s);
        return (s >= SUB_CHAN_RESET && s <= SUB_WCS_ENABLE) ||
            s == SUB_WCS_WRITE;
    endfunction

    function automatic logic cc_assigned(input logic [3:0] c);
        return c <= CC_UNSUPPORTED || c == CC_QUEUED;
    endfunction
endpackage

// File: logic/cioc_wcs_interlock.sv
// control store load interlock, one channel at a time
`timescale 1ns/1ns
`default_nettype none
module cioc_wcs_interlock
    import cioc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_issue,
    input wire logic [3:0] i_sub_op,
    input wire logic [CHAN_W-1:0] i_chan,
    output logic o_armed,
    output logic [CHAN_W-1:0] o_chan
);
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_armed <= 1'b0;
            o_chan <= 8'h00;
        end else if (i_issue) begin
            if (i_sub_op == SUB_WCS_ENABLE) begin
                o_armed <= 1'b1; // [RULE13]
                o_chan <= i_chan;
            end else if (i_chan == o_chan) begin
                // anything else to that channel breaks the pair
                o_armed <= 1'b0; // [RULE20]
            end
        end
    end
endmodule
`default_nettype wire

// File: test/channel_io_control_decoder_test.sv
// self-checking bench for the channel control instruction decoder
`timescale 1ns/1ns
`default_nettype none
module channel_io_control_decoder_test
    import cioc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic [31:0] instr = 32'h0000_0000;
    logic [3:0] baddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic busy = 1'b0;
    logic [3:0] m_cc = 4'h0;
    logic [7:0] m_delay = 8'h02;
    logic m_dup = 1'b0;
    logic [2:0] reg_sel;
    logic [31:0] rdata;
    logic req;
    logic [3:0] op;
    logic [CONST_W-1:0] caddr;
    logic ack;
    logic [3:0] ccin;
    logic endin;
    logic [CHAN_W-1:0] endch;
    logic dev_end;
    logic [3:0] cc;
    logic done;
    logic reject;
    logic tu;
    logic ts;
    int n_fail = 0;
    int check_count = 0;
    int req_cnt = 0;
    int dev_cnt = 0;
    int ends0;

    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (req === 1'b1) req_cnt++;
        if (dev_end === 1'b1) dev_cnt++;
    end

    // upper register half must drop out of the 16-bit sum
    cioc_decoder u_cioc_decoder (.i_mclk(clk), .i_reset(rst),
        .i_instr_valid(valid), .i_instr(instr), .o_reg_sel(reg_sel),
        .i_reg_data(32'h1234_FF00), .i_bus_addr(baddr),
        .i_bus_wdata(wdata), .i_bus_wr(wr), .i_bus_rd(rd),
        .o_bus_rdata(rdata), .o_chan_req(req), .o_chan_op(op),
        .o_chan_addr(caddr), .i_chan_busy(busy), .i_chan_ack(ack),
        .i_chan_cc(ccin), .i_chan_dev_end(endin),
        .i_chan_dev_chan(endch), .o_dev_end(dev_end), .o_cc(cc),
        .o_done(done), .o_reject(reject), .o_trap_undef(tu),
        .o_trap_syscheck(ts));
    cioc_chan_model u_cioc_chan_model (.i_mclk(clk), .i_reset(rst),
        .i_chan_req(req), .i_chan_op(op), .i_chan_addr(caddr),
        .i_cc(m_cc), .i_delay(m_delay), .i_dup_end(m_dup),
        .o_chan_ack(ack), .o_chan_cc(ccin), .o_chan_dev_end(endin),
        .o_chan_dev_chan(endch));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        baddr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        baddr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("bus read", exp, rdata);
    endtask

    function automatic logic [31:0] mk(input logic [3:0] s,
            input logic [2:0] r, input logic [15:0] k);
        return {OPCODE_IO, r, s, AUG_IO, k};
    endfunction

    // outcome one-hot: 8 done, 4 undefined trap, 2 system check, 1 reject
    task automatic run(input logic [31:0] w, input logic [3:0] kind,
            input logic [3:0] ecc, input int ereq, input logic [15:0] ea);
        logic [3:0] cc0;
        int reqs0;
        int n;
        cc0 = cc;
        reqs0 = req_cnt;
        n = 0;
        @(posedge clk);
        valid <= 1'b1;
        instr <= w;
        @(posedge clk);
        valid <= 1'b0;
        #1;
        while ({done, tu, ts, reject} === 4'h0 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 300) begin
            n_fail++;
            complete_run();
        end
        chk("outcome", 32'(kind), 32'({done, tu, ts, reject}));
        chk("cc", 32'(kind == 4'h8 ? ecc : cc0), 32'(cc));
        chk("requests", 32'(ereq), 32'(req_cnt - reqs0));
        if (ereq != 0) begin
            chk("chan addr", 32'(ea), 32'(caddr));
            chk("chan op", 32'(w[22:19]), 32'(op));
            chk("reg sel", 32'(w[25:23]), 32'(reg_sel));
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        bus_rd(REG_STATUS, 32'h0000_0000);
        bus_rd(4'hC, 32'h0000_0000);
        run(mk(4'h5, 3'h0, 16'h1200), 4'h8, CC_CHAN_INOP, 0, 0);
        bus_wr(REG_CLASS, 32'h0000_0312);
        bus_wr(REG_CLASS, 32'h0000_0134);
        bus_rd(REG_CLASS, 32'h0000_0134);
        // sub ops 5 to 9, alternating both accepted codes
        for (int s = 5; s <= 9; s++) begin
            m_cc <= s[0] ? CC_QUEUED : CC_ACTIVATED;
            run(mk(4'(s), 3'h0, 16'h1255), 4'h8,
                s[0] ? CC_QUEUED : CC_ACTIVATED, 1, 16'h1255);
        end
        bus_rd(REG_STATUS, 32'h0000_1218);
        m_cc <= CC_ACTIVATED;
        // enable then write, nothing to that channel in between
        run(mk(SUB_WCS_WRITE, 3'h0, 16'h1200), 4'h8, 0, 1, 16'h1200);
        run(mk(SUB_WCS_WRITE, 3'h0, 16'h1200), 4'h2, 0, 0, 0);
        run(mk(4'h5, 3'h3, 16'h1300), 4'h8, 0, 1, 16'h1200);
        run(mk(4'h5, 3'h0, 16'h1200), 4'h8, 0, 1, 16'h1200);
        bus_rd(REG_ADDR, 32'h0000_1200);
        run(mk(4'h6, 3'h0, 16'h3400), 4'h4, 0, 0, 0);
        run(mk(4'h5, 3'h0, 16'h1200) ^ 32'h0400_0000, 4'h1, 0, 0, 0);
        run(mk(4'h5, 3'h0, 16'h1200) ^ 32'h0001_0000, 4'h1, 0, 0, 0);
        run(mk(4'hA, 3'h0, 16'h1200), 4'h1, 0, 0, 0);
        busy <= 1'b1;
        run(mk(4'h7, 3'h0, 16'h1200), 4'h8, CC_CHAN_BUSY, 0, 0);
        busy <= 1'b0;
        // refusal codes pass through, an unassigned one is folded
        for (int c = 1; c <= 6; c++) begin
            m_cc <= 4'(c);
            run(mk(4'h8, 3'h0, 16'h1201), 4'h8,
                c == 6 ? CC_UNSUPPORTED : 4'(c), 1, 16'h1201);
        end
        m_cc <= CC_ACTIVATED;
        m_dup <= 1'b1;
        ends0 = dev_cnt;
        run(mk(4'h6, 3'h0, 16'h1200), 4'h8, 0, 1, 16'h1200);
        repeat (12) @(posedge clk);
        #1 chk("device ends", 32'h1, 32'(dev_cnt - ends0));
        m_dup <= 1'b0;
        m_delay <= 8'hFF;
        run(mk(4'h7, 3'h0, 16'h1200), 4'h8, CC_CHAN_INOP, 1, 16'h1200);
        complete_run();
    end
endmodule
`default_nettype wire

// File: test/cioc_chan_model.sv
// behavioural channel and controller model facing the decoder
`timescale 1ns/1ns
`default_nettype none
module cioc_chan_model
    import cioc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_chan_req,
    input wire logic [3:0] i_chan_op,
    input wire logic [CONST_W-1:0] i_chan_addr,
    input wire logic [3:0] i_cc,
    input wire logic [7:0] i_delay,
    input wire logic i_dup_end,
    output logic o_chan_ack,
    output logic [3:0] o_chan_cc,
    output logic o_chan_dev_end,
    output logic [CHAN_W-1:0] o_chan_dev_chan
);
    logic pend_q;
    logic halt_q;
    logic [7:0] wait_q;
    logic [2:0] end_q;
    // ****************************************
    // answer path
    // ****************************************
    // delay 8'hff is a dead channel; cc toggles when not qualified by ack
    always_ff @(posedge i_mclk) begin
        o_chan_ack <= 1'b0;
        o_chan_cc <= ~o_chan_cc;
        o_chan_dev_end <= 1'b0;
        if (i_reset) begin
            pend_q <= 1'b0;
            end_q <= 3'h0;
            o_chan_cc <= 4'h0;
        end else if (i_chan_req) begin
            pend_q <= i_delay != 8'hFF;
            wait_q <= i_delay;
            halt_q <= i_chan_op == SUB_CTL_HALT;
            o_chan_dev_chan <= i_chan_addr[15:8];
        end else if (pend_q && wait_q == 8'h00) begin
            // channel and controller effects land here; the interlock already moved at issue
            pend_q <= 1'b0;
            o_chan_ack <= 1'b1;
            o_chan_cc <= i_cc;
            if (halt_q) begin
                end_q <= i_dup_end ? 3'h4 : 3'h2;
            end
        end else if (pend_q) begin
            wait_q <= wait_q - 8'h01;
        end
        // a duplicate end only when the bench commands it
        if (end_q != 3'h0 && !i_reset) begin
            end_q <= end_q - 3'h1;
            o_chan_dev_end <= end_q[0];
        end
    end
endmodule
`default_nettype wire
